// >>> rtl/rtc_bus_guard.sv
`timescale 1ns/1ps
`include "rtc_guard_defs.svh"

module rtc_bus_guard #(
  parameter int TW = `TIMER_WIDTH,
  parameter logic [TW-1:0] TIMEOUT_MIN_CYCLES = TW'(`TIMEOUT_MIN_CYCLES),
  parameter logic [TW-1:0] TIMEOUT_MAX_CYCLES = TW'(`TIMEOUT_MAX_CYCLES),
  parameter logic [TW-1:0] OSC_STOP_CYCLES = TW'(`OSC_STOP_CYCLES),
  parameter logic [TW-1:0] OSC_MISS_CYCLES = TW'(`OSC_MISS_CYCLES)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic osc_clk,
  input wire rtc_guard_pkg::bus_pins_type bus_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic engine_sda_low,
  input wire logic engine_write_req,
  output logic engine_write_commit,
  output logic engine_bus_reset,
  output logic lockup_detected,
  output logic oscillator_stop_flag,
  input wire logic osc_stop_clear,
  input wire rtc_guard_pkg::pin_config_type pin_config,
  input wire logic alarm_irq,
  output logic first_irq_out_n,
  output logic first_irq_oe_n,
  input wire logic ref_clock_in,
  output logic ref_clock_sync,
  output logic second_irq_out_n
);

  // Crystal domain: a toggle per crystal cycle tells the system side the
  // oscillator is alive, and a divider builds the square wave.
  logic osc_toggle;
  logic [`SQW_DIV_WIDTH-1:0] sqw_div;
  logic [1:0] osc_mode_sync;
  logic [1:0] osc_alarm_sync;
  logic [7:0] osc_sel_sync;
  logic second_pin;

  wire [`SQW_DIV_WIDTH:0] sqw_taps = {sqw_div, osc_clk};
  wire sqw_bit = sqw_taps[osc_sel_sync[7:4]];
  wire next_second_pin = osc_mode_sync[1] ? sqw_bit : ~osc_alarm_sync[1];

  // Tap zero is the crystal clock itself; sampled on its own rising edge
  // it reads as a steady high, so that setting only suits a quiet pin.
  // Every other tap is a clean registered divide by a power of two.

  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_toggle <= 1'b0;
      sqw_div <= '0;
    end else begin
      osc_toggle <= ~osc_toggle;
      sqw_div <= sqw_div + 1'b1;
    end
  end

  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_mode_sync <= 2'b00;
      osc_alarm_sync <= 2'b00;
      osc_sel_sync <= 8'h00;
      second_pin <= 1'b1;
    end else begin
      osc_mode_sync <= {osc_mode_sync[0], pin_config.square_wave_mode};
      osc_alarm_sync <= {osc_alarm_sync[0], alarm_irq};
      osc_sel_sync <= {osc_sel_sync[3:0], pin_config.square_wave_sel};
      second_pin <= next_second_pin;
    end
  end

  assign second_irq_out_n = second_pin;

  // System domain: synchronisers for the bus pins, the crystal toggle and
  // the reference clock pin.
  // Logic reads the second stage only; the third stage of the bus pins and the crystal toggle
  // serves edge detection. The bus stages reset high like the idle lines,
  // so no false clock rise or START follows reset. The crystal toggle
  // resets low to match the crystal side.
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] osc_sync;
  logic [1:0] ref_sync;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 3'b111;
      sda_sync <= 3'b111;
      osc_sync <= 3'b000;
      ref_sync <= 2'b00;
    end else begin
      scl_sync <= {scl_sync[1:0], bus_in.scl};
      sda_sync <= {sda_sync[1:0], bus_in.sda};
      osc_sync <= {osc_sync[1:0], osc_toggle};
      ref_sync <= {ref_sync[0], ref_clock_in};
    end
  end

  wire scl_now = scl_sync[1];
  wire scl_rise = scl_sync[1] & ~scl_sync[2];
  wire start_seen = scl_now & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
  wire stop_seen = scl_now & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
  wire osc_edge = osc_sync[1] ^ osc_sync[2];

  // Oscillator watch: counts system cycles since the last crystal edge.
  // The gap counter saturates rather than wraps, so a long dead crystal
  // still reads as stopped. A few missing edges drop osc_running long
  // before the stop flag, and osc_running is what gates the idle timer.
  logic [TW-1:0] osc_gap;
  logic osc_running;
  wire osc_stopped_long = osc_gap >= OSC_STOP_CYCLES;
  wire osc_gap_full = &osc_gap;
  wire osc_recent = osc_gap < OSC_MISS_CYCLES;
  wire next_osc_running = osc_edge | (osc_running & osc_recent);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_gap <= '0;
      osc_running <= 1'b0;
      oscillator_stop_flag <= 1'b0;
    end else begin
      osc_gap <= osc_edge ? '0 : (osc_gap_full ? osc_gap : osc_gap + 1'b1);
      osc_running <= next_osc_running;
      // Set wins over a clear arriving in the same cycle, so software
      // cannot lose a stop that is still in progress.
      if (osc_stopped_long)
        oscillator_stop_flag <= 1'b1;
      else if (osc_stop_clear)
        oscillator_stop_flag <= 1'b0;
    end
  end

  // Idle timer and lockup state machine.
  // The timer freezes rather than clears when the crystal dies, so a low
  // phase that spans an oscillator dropout is still timed once it returns.
  // Clearing on any high level covers the rising edge and both START and
  // STOP, which can only occur with the clock high.
  logic [TW-1:0] idle_timer;
  rtc_guard_pkg::guard_state_type state;
  rtc_guard_pkg::guard_state_type next_state;

  wire timer_clear = scl_rise | start_seen | stop_seen | scl_now;
  wire timer_run = ~scl_now & osc_running;
  wire past_min = idle_timer >= TIMEOUT_MIN_CYCLES;
  wire past_max = idle_timer >= TIMEOUT_MAX_CYCLES;
  wire timer_full = &idle_timer;

  always_comb begin
    next_state = state;
    case (state)
      rtc_guard_pkg::bus_active: begin
        if (timer_clear)
          next_state = rtc_guard_pkg::bus_active;
        else if (past_min)
          next_state = rtc_guard_pkg::bus_suspect;
      end
      rtc_guard_pkg::bus_suspect: begin
        if (timer_clear)
          next_state = rtc_guard_pkg::bus_active;
        else if (past_max)
          next_state = rtc_guard_pkg::bus_locked;
      end
      rtc_guard_pkg::bus_locked: begin
        // Held in reset until the line recovers; a START then finds the
        // engine idle and ready.
        if (scl_rise | start_seen | stop_seen)
          next_state = rtc_guard_pkg::bus_active;
      end
      // An illegal one-hot code falls back to the safe active state.
      default: next_state = rtc_guard_pkg::bus_active;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_timer <= '0;
      state <= rtc_guard_pkg::bus_active;
    end else begin
      if (timer_clear)
        idle_timer <= '0;
      else if (timer_run & ~timer_full)
        idle_timer <= idle_timer + 1'b1;
      state <= next_state;
    end
  end

  wire locked = state == rtc_guard_pkg::bus_locked;
  wire suspect = state == rtc_guard_pkg::bus_suspect;

  // The engine reset only idles the protocol logic; stored registers live
  // behind the write commit and are never reset by it.
  assign engine_bus_reset = locked;
  assign lockup_detected = suspect | locked;
  // A byte not yet acknowledged when the timeout fires is dropped.
  // The gate uses the timer compare as well as the state, so a commit in
  // the very cycle the limit is reached is refused too.
  assign engine_write_commit = engine_write_req & ~locked & ~past_max;

  // Pin drivers, all from flip-flops.
  // The data line is released on the same edge that enters the locked state, from
  // the same compare, so the bus never sees the device pull low while its
  // interface is in reset. The first pin is never driven in reference
  // clock mode, where it serves as an input.
  wire next_sda_oe_n = ~(engine_sda_low & ~locked & ~past_max);
  wire next_first_oe_n = pin_config.ref_clock_mode | ~alarm_irq;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_oe_n <= 1'b1;
      first_irq_oe_n <= 1'b1;
      ref_clock_sync <= 1'b0;
    end else begin
      sda_oe_n <= next_sda_oe_n;
      first_irq_oe_n <= next_first_oe_n;
      ref_clock_sync <= ref_sync[1] & pin_config.ref_clock_mode;
    end
  end

  // Open-drain pins only ever drive low; the enables decide.
  assign sda_out = 1'b0;
  assign first_irq_out_n = 1'b0;

endmodule

// >>> rtl/rtc_guard_defs.svh
// Operation
// - Flag any single clock low phase longer than the minimum idle limit.
// - After the maximum idle limit, reset the serial interface for START.
// - On the over-long clock low, stop pulling the data line low.
// - Lockup detection works only while the crystal oscillator is running.
// - Set the oscillator stop flag only after a continuous stop time.
// - Second pin carries square wave or active-low alarm, push-pull.
// - First pin is open-drain alarm output or external reference clock input.
// - Time base comes from a 32.768kHz crystal across the crystal pins.
// - Idle limit lies between 25 ms and 35 ms of clock low.
// - Oscillator stop detection time is 30 ms typical, 100 ms at most.
// - A write cut off before its acknowledge is discarded, target unchanged.
`ifndef RTC_GUARD_DEFS_SVH
`define RTC_GUARD_DEFS_SVH

`define CLK_KHZ 25000
`define CRYSTAL_HZ 32768
`define TIMEOUT_MIN_MS 25
`define TIMEOUT_MAX_MS 35
`define OSC_STOP_MS 30
`define OSC_STOP_MAX_MS 100
`define TIMEOUT_MIN_CYCLES (`TIMEOUT_MIN_MS * `CLK_KHZ)
`define TIMEOUT_MAX_CYCLES (`TIMEOUT_MAX_MS * `CLK_KHZ)
`define OSC_STOP_CYCLES (`OSC_STOP_MS * `CLK_KHZ)
`define OSC_MISS_CYCLES 2048
`define TIMER_WIDTH 20
`define SQW_DIV_WIDTH 15

`endif

// >>> rtl/rtc_guard_pkg.sv
package rtc_guard_pkg;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_type;

  typedef struct packed {
    logic ref_clock_mode;
    logic square_wave_mode;
    logic [3:0] square_wave_sel;
  } pin_config_type;

  typedef enum logic [2:0] {
    bus_active = 3'b001,
    bus_suspect = 3'b010,
    bus_locked = 3'b100
  } guard_state_type;

endpackage

// >>> tb/rtc_guard_props.sv
`timescale 1ns/1ps
module rtc_guard_props #(parameter int MIN = 40, parameter int MAX = 60) (
  input wire logic clk,
  input wire logic reset_n,
  input wire rtc_guard_pkg::bus_pins_type bus_in,
  input wire logic sda_oe_n,
  input wire logic engine_write_commit,
  input wire logic engine_bus_reset,
  input wire logic lockup_detected,
  input wire logic oscillator_stop_flag,
  input wire logic osc_stop_clear,
  input wire rtc_guard_pkg::pin_config_type pin_config,
  input wire logic alarm_irq,
  input wire logic first_irq_oe_n,
  input wire logic ref_clock_sync
);
  // Raw low run of the clock pin, counted before any synchroniser.
  int low_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) low_cnt <= 0;
    else low_cnt <= bus_in.scl ? 0 : low_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence scl_high_s;
    bus_in.scl [*5];
  endsequence
  // The flags may rise after the pin has gone high again, as the pin runs
  // through two synchroniser stages; the low run is taken two edges back.
  detect_time_a: assert property (
    $rose(lockup_detected) |-> $past(low_cnt, 2) >= MIN)
    else $error("lockup flag early");
  reset_time_a: assert property (
    $rose(engine_bus_reset) |-> $past(low_cnt, 2) >= MAX)
    else $error("bus reset early");
  reset_order_a: assert property (
    engine_bus_reset |-> lockup_detected)
    else $error("bus reset without lockup flag");
  sda_release_a: assert property (
    engine_bus_reset |-> sda_oe_n)
    else $error("data line held in lockout");
  write_gate_a: assert property (
    engine_bus_reset |-> !engine_write_commit)
    else $error("write committed in lockout");
  scl_clears_a: assert property (
    scl_high_s |-> !lockup_detected)
    else $error("lockup kept with clock high");
  flag_hold_a: assert property (
    oscillator_stop_flag && !osc_stop_clear |=> oscillator_stop_flag)
    else $error("stop flag lost");
  first_pin_a: assert property (
    $past(reset_n) |-> first_irq_oe_n ==
    !($past(alarm_irq) && !$past(pin_config.ref_clock_mode)))
    else $error("first pin drive wrong");
  ref_idle_a: assert property (
    !pin_config.ref_clock_mode [*2] |-> !ref_clock_sync)
    else $error("reference clock seen when unused");
endmodule

// >>> tb/rtc_bus_ctrl.sv
`timescale 1ns/1ps
module rtc_bus_ctrl (
  input wire logic clk,
  input wire logic sda_oe_n,
  output rtc_guard_pkg::bus_pins_type pins
);
  logic scl = 1'b1;
  logic sda = 1'b1;
  // Both lines have pull-ups, so whoever pulls low wins.
  assign pins = {scl, sda & sda_oe_n};
  // Normal lows stay under the idle limit; longer ones are commanded.
  task automatic pull(input int n);
    @(posedge clk);
    #1 scl = 1'b0;
    sda = 1'($urandom);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rel();
    scl = 1'b1;
    repeat (5) @(posedge clk);
    #1;
  endtask
endmodule

// >>> tb/tb_rtc_bus_timeout_and_shared_pins.sv
`timescale 1ns/1ps
module tb_rtc_bus_timeout_and_shared_pins;
  logic clk = 0, osc_raw = 0, osc_en = 1, reset_n = 0;
  logic engine_sda_low = 0, engine_write_req = 0, osc_stop_clear = 0;
  logic alarm_irq = 0, ref_clock_in = 0;
  rtc_guard_pkg::pin_config_type pin_config = '0;
  rtc_guard_pkg::bus_pins_type bus_in;
  logic sda_out, sda_oe_n, engine_write_commit, engine_bus_reset;
  logic lockup_detected, oscillator_stop_flag, first_irq_out_n;
  logic first_irq_oe_n, ref_clock_sync, second_irq_out_n;
  logic [2:0] e;
  logic last;
  int corner[5] = '{32'h2a, 32'h2b, 32'h3e, 32'h3f, 32'h46};
  int n_errors = 0, cmp_count = 0, cyc = 0, n;
  wire osc_clk = osc_raw & osc_en;
  always #20 clk = ~clk;
  always #15 osc_raw = ~osc_raw;
  rtc_bus_ctrl ctl(.clk(clk), .sda_oe_n(sda_oe_n), .pins(bus_in));
  rtc_bus_guard #(.TIMEOUT_MIN_CYCLES(20'h28), .TIMEOUT_MAX_CYCLES(20'h3c),
    .OSC_STOP_CYCLES(20'h64), .OSC_MISS_CYCLES(20'h10)) DUT(.*);
  task automatic cmp(input logic a, input logic x);
    cmp_count++;
    if (a !== x) begin
      n_errors++;
      $display("MISMATCH %0t value differs", $time);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Pin to timer takes two synchroniser stages and one count, the flags
  // one more edge; the write gate acts on the compare itself.
  function automatic logic [2:0] exp_lock(input int len);
    return {len >= 32'h3c + 2, len >= 32'h3c + 3, len >= 32'h28 + 3};
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(79));
    repeat (10) @(posedge clk);
    #1 reset_n = 1;
    repeat (10) @(posedge clk);
    #1 cmp(oscillator_stop_flag, 1'b0);
    cmp(sda_out | first_irq_out_n, 1'b0);
    // Random short lows first, then runs on either side of both limits.
    for (int i = 0; i < 12; i++) begin
      {engine_sda_low, engine_write_req} = 2'($urandom);
      n = i < 7 ? $urandom_range(35, 1) : corner[i - 7];
      e = exp_lock(n);
      ctl.pull(n);
      cmp(lockup_detected, e[0]);
      cmp(engine_bus_reset, e[1]);
      cmp(sda_oe_n, !engine_sda_low | e[1]);
      cmp(engine_write_commit, engine_write_req & !e[2]);
      ctl.rel();
      cmp(lockup_detected | engine_bus_reset, 1'b0);
    end
    engine_write_req = 0;
    osc_en = 0;
    ctl.pull(60);
    cmp(oscillator_stop_flag, 1'b0);
    ctl.pull(60);
    cmp(engine_bus_reset, 1'b0);
    cmp(oscillator_stop_flag, 1'b1);
    osc_en = 1;
    ctl.rel();
    osc_stop_clear = 1;
    @(posedge clk);
    #1 osc_stop_clear = 0;
    @(posedge clk);
    #1 cmp(oscillator_stop_flag, 1'b0);
    for (int i = 0; i < 8; i++) begin
      {alarm_irq, ref_clock_in, pin_config} = 8'($urandom);
      repeat (8) @(posedge clk);
      #1;
      cmp(first_irq_oe_n, !(alarm_irq & !pin_config.ref_clock_mode));
      cmp(ref_clock_sync, ref_clock_in & pin_config.ref_clock_mode);
      if (!pin_config.square_wave_mode) begin
        cmp(second_irq_out_n, !alarm_irq);
      end
    end
    // Divide by eight toggles every 120 ns, so 800 ns show six or seven.
    pin_config = 6'h13;
    repeat (8) @(posedge clk);
    #1 last = second_irq_out_n;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (second_irq_out_n !== last) n++;
      last = second_irq_out_n;
    end
    cmp(n >= 32'h5 && n <= 32'h8, 1'b1);
    stop_test();
  end
endmodule
bind rtc_bus_guard rtc_guard_props chk(.*);
